// File: hdl/csatw_pkg.sv
// Purpose: Constants for the clock sources and tick counters block.
// Assumes: APB slave on clk_sys at 10 MHz; oscillator pins are asynchronous.
// Notes:   Summary of operation
// Summary of operation
// R1: Central counter, 13 bits, counts 1 kHz edges.
// R2: Central counter stops in hibernate or debug halt.
// R3: Central counter gives periodic interrupts and wakeup.
// R4: Firmware write clears the central counter.
// R5: Fast counter, 5 bits, 100 kHz, programmable terminal.
// R6: Fast counter returns to zero at terminal count.
// R7: Fast counter interrupts at terminal only when enabled.
// R8: Low-speed clocks offered at 1, 33, 100 kHz.
// R9: Third-rate clock is 100 kHz divided by three.
// R10: Multiplier reference: main osc, crystal, or interconnect.
// R11: Multiplier lock within 250 us, readable status.
// R12: Multiplier usable before lock; lock bit set after.
// R13: Lock indication is routed out for interrupts.
// R14: Input and feedback dividers give 4032 ratios.
// R15: Firmware disables multiplier before low-power mode.
// R16: Doubler makes 48 MHz from 24 MHz.
// R17: Main oscillator frequency selects 3, 6, 12, 24 MHz.
// R18: Processor clock divider has a 4-bit setting.
// R19: Eight independently sourced 16-bit clock dividers.
// R20: One-second interrupt from the 32.768 kHz watch crystal.
// R21: Dividers divide by two or more, even duty; odd ratios stay high for the smaller half of the period.
// R22: Processor divider is fed from the bus clock.
// R23: Tick flags sticky until cleared, gated by enable.
// R24: Multiplier configuration change clears lock until relocked.
package csatw_pkg;
  localparam int          CLK_MHZ      = 10;
  localparam int          LOCK_TIME_US = 250;
  localparam int          LOCK_CYC     = LOCK_TIME_US * CLK_MHZ;
  localparam logic [14:0] SEC_LAST     = 15'h7fff;
  localparam logic [1:0]  DIV3_LAST    = 2'h2;
  // Register byte offsets.
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_PLLDIV   = 8'h04;
  localparam logic [7:0]  OFF_TICKCTL  = 8'h08;
  localparam logic [7:0]  OFF_FLAGS    = 8'h0c;
  localparam logic [7:0]  OFF_COUNT    = 8'h10;
  localparam logic [7:0]  OFF_BUSDIV   = 8'h14;
  localparam logic [7:0]  OFF_CPUDIV   = 8'h18;
  localparam logic [7:0]  OFF_DCLK0    = 8'h20;
  localparam logic [7:0]  OFF_DCLK7    = 8'h3c;
  // Field positions.
  localparam int          TC_CLEAR_BIT = 16;
  localparam int          FL_CTW       = 0;
  localparam int          FL_FTW       = 1;
  localparam int          FL_SEC       = 2;
  localparam int          PIN_1K       = 0;
  localparam int          PIN_100K     = 1;
  localparam int          PIN_WATCH    = 2;
  localparam int          PIN_DSI      = 3;
  localparam int          PIN_XTAL     = 4;
  // Reset values.
  localparam logic [4:0]  RST_FTW_TC   = 5'h1f;
  localparam logic [3:0]  RST_CTW_SEL  = 4'h9;
  localparam logic [5:0]  RST_PLL_P    = 6'h01;
  localparam logic [5:0]  RST_PLL_Q    = 6'h08;
  localparam logic [15:0] RST_BUS_DIV  = 16'h0002;
  localparam logic [3:0]  RST_CPU_DIV  = 4'h2;
  localparam logic [15:0] RST_DCLK_DIV = 16'h0002;
endpackage : csatw_pkg

// File: hdl/csatw_clkdiv.sv
// Purpose: One clock divider, resynchronised to the master clock.
// Assumes: src_tick is a one-cycle enable on clk_sys.
// Notes:   A setting below two divides by two.
`timescale 1ns/1ns
module csatw_clkdiv #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,  // Master clock
  input  wire logic         sys_rst,  // Async reset, high
  input  wire logic         src_tick, // Source edge enable
  input  wire logic [W-1:0] div,      // Divide ratio
  output logic              clk_out,  // Divided level
  output logic              tick      // Rising edge pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         lvl;
    logic         pls;
  } csatw_div_t;

  csatw_div_t st;
  csatw_div_t next_st;
  logic [W-1:0] eff;

  always_comb begin
    eff = (div < W'(2)) ? W'(2) : div; // R21
    next_st = st;
    next_st.pls = 1'b0;
    if (src_tick) begin
      if (st.cnt >= eff - W'(1)) begin
        next_st.cnt = '0;
        next_st.pls = 1'b1;
      end else begin
        next_st.cnt = st.cnt + W'(1);
      end
      next_st.lvl = (next_st.cnt < (eff >> 1)); // R21
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_out = st.lvl;
  assign tick    = st.pls;
endmodule : csatw_clkdiv

// File: hdl/csatw_top.sv
// Purpose: Clock source selection, dividers and tick counters with APB.
// Assumes: Oscillator pins are asynchronous; mode inputs are on clk_sys.
// Notes:   Multiplier lock is timed digitally from enable or reconfiguration.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module csatw_top
  import csatw_pkg::*;
(
  input  wire logic        clk_sys,         // Master clock 10 MHz
  input  wire logic        sys_rst,         // Async reset, high
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB write
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic [31:0]      prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        slow_osc_1k,     // 1 kHz oscillator pin
  input  wire logic        fast_osc_100k,   // 100 kHz oscillator pin
  input  wire logic        watch_xtal_osc,  // 32.768 kHz crystal pin
  input  wire logic        dsi_clk,         // Interconnect clock pin
  input  wire logic        fast_crystal_osc,// Fast crystal pin
  input  wire logic        hibernate,       // Hibernate mode
  input  wire logic        debug_halt,      // CPU halted by debug
  output logic             pll_en,          // Multiplier enable
  output logic [1:0]       pll_ref,         // Multiplier reference select
  output logic [5:0]       pll_p,           // Multiplier input divider
  output logic [5:0]       pll_q,           // Multiplier feedback divider
  output logic             pll_lock_out,    // Lock to interconnect
  output logic [1:0]       imo_freq,        // Main osc frequency select
  output logic             dbl_en,          // Doubler enable
  output logic [1:0]       dbl_src,         // Doubler source select
  output logic             slow_tick_clock, // 1 kHz edge pulse
  output logic             fast_low_power_clock, // 100 kHz edge pulse
  output logic             third_rate_clock,// 33 kHz pulse
  output logic             ctw_irq,         // Central counter irq
  output logic             ftw_irq,         // Fast counter irq
  output logic             sec_irq,         // One-second irq
  output logic             wake,            // Wake pulse
  output logic             bus_clk,         // Bus clock level
  output logic             cpu_clk,         // Processor clock level
  output logic [7:0]       dclk             // Digital clocks
);
  typedef struct packed {
    logic [4:0]       s1;
    logic [4:0]       s2;
    logic [4:0]       s3;
    logic             pll_en;
    logic [1:0]       pll_ref;
    logic [5:0]       pll_p;
    logic [5:0]       pll_q;
    logic [11:0]      lock_cnt;
    logic             locked;
    logic [1:0]       imo_freq;
    logic             dbl_en;
    logic [1:0]       dbl_src;
    logic             ctw_ie;
    logic             ftw_ie;
    logic             sec_ie;
    logic             wake_en;
    logic [3:0]       ctw_sel;
    logic [4:0]       ftw_tc;
    logic [2:0]       flags;
    logic [12:0]      central_tick_counter;
    logic [4:0]       ftw;
    logic [1:0]       div3;
    logic [14:0]      sec_cnt;
    logic             slow_t;
    logic             fast_t;
    logic             third_t;
    logic             wake;
    logic [2:0]       irq;
    logic [15:0]      bus_div;
    logic [3:0]       cpu_div;
    logic [7:0][15:0] dc_div;
    logic [7:0][2:0]  dc_src;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } csatw_state_t;

  localparam logic [11:0] LOCK_LAST = 12'(LOCK_CYC - 1);

  csatw_state_t st;
  csatw_state_t next_st;
  logic [4:0]   rise;
  logic         wr;
  logic         cfg_chg;
  logic         ctw_clr;
  logic         ctw_adv;
  logic         bus_tick;
  logic [7:0]   srcv;
  logic [2:0]   fset;

  function automatic logic dclk_hit(input logic [7:0] a);
    dclk_hit = (a >= OFF_DCLK0) && (a <= OFF_DCLK7) && (a[1:0] == 2'h0);
  endfunction : dclk_hit

  function automatic logic [12:0] csatw_pmask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > 4'hc) ? 4'hc : sel;
    csatw_pmask = 13'h1fff >> (4'hc - s);
  endfunction : csatw_pmask

  // Edges are detected only past the second synchroniser stage.
  assign rise    = st.s2 & ~st.s3;
  assign wr      = psel & penable & st.pready & pwrite & ~st.pslverr;
  assign ctw_clr = wr && paddr == OFF_TICKCTL && pwdata[TC_CLEAR_BIT];
  assign cfg_chg = wr && ((paddr == OFF_CTRL && pwdata[2:1] != st.pll_ref)
                   || (paddr == OFF_PLLDIV
                       && {pwdata[13:8], pwdata[5:0]} != {st.pll_q, st.pll_p}));
  assign ctw_adv = rise[PIN_1K] & ~hibernate & ~debug_halt;
  assign srcv    = {rise[PIN_XTAL], bus_tick, rise[PIN_DSI], rise[PIN_WATCH],
                    st.slow_t, st.third_t, st.fast_t, 1'b1};

  always_comb begin
    next_st = st;
    fset    = 3'h0;
    next_st.s1 = {fast_crystal_osc, dsi_clk, watch_xtal_osc,
                  fast_osc_100k, slow_osc_1k};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.slow_t = rise[PIN_1K];   // R8
    next_st.fast_t = rise[PIN_100K]; // R8
    next_st.third_t = 1'b0;
    next_st.wake = 1'b0;

    // Central counter.
    if (ctw_clr) begin
      next_st.central_tick_counter = 13'h0000; // R4
    end else if (ctw_adv) begin
      next_st.central_tick_counter = st.central_tick_counter + 13'h0001; // R1 R2
      if ((next_st.central_tick_counter & csatw_pmask(st.ctw_sel)) == 13'h0000) begin
        fset[FL_CTW] = st.ctw_ie; // R3 R23
        next_st.wake = st.wake_en; // R3
      end
    end

    // Fast counter and the divide-by-three.
    if (rise[PIN_100K]) begin
      if (st.ftw == st.ftw_tc) begin
        next_st.ftw = 5'h00; // R6
        fset[FL_FTW] = st.ftw_ie; // R7 R23
      end else begin
        next_st.ftw = st.ftw + 5'h01; // R5
      end
      if (st.div3 == DIV3_LAST) begin
        next_st.div3 = 2'h0;
        next_st.third_t = 1'b1; // R9
      end else begin
        next_st.div3 = st.div3 + 2'h1; // R9
      end
    end

    // One-second tick from the watch crystal.
    if (rise[PIN_WATCH]) begin
      if (st.sec_cnt == SEC_LAST) begin
        next_st.sec_cnt = 15'h0000;
        fset[FL_SEC] = st.sec_ie; // R20 R23
      end else begin
        next_st.sec_cnt = st.sec_cnt + 15'h0001;
      end
    end

    // Lock timing; output stays usable, only the status waits.
    if (!st.pll_en || cfg_chg) begin
      next_st.lock_cnt = 12'h000; // R24
      next_st.locked = 1'b0; // R24
    end else if (!st.locked) begin
      if (st.lock_cnt == LOCK_LAST) begin
        next_st.locked = 1'b1; // R11 R12
      end else begin
        next_st.lock_cnt = st.lock_cnt + 12'h001;
      end
    end

    // APB: answer one cycle into the access phase.
    next_st.pready = psel & penable & ~st.pready;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    if (psel & penable & ~st.pready) begin
      if (paddr == OFF_CTRL) begin
        next_st.prdata = {24'h0, st.dbl_src, st.dbl_en, st.imo_freq,
                          st.pll_ref, st.pll_en};
      end else if (paddr == OFF_PLLDIV) begin
        next_st.prdata = {15'h0, st.locked, 2'h0, st.pll_q, 2'h0, st.pll_p}; // R11
      end else if (paddr == OFF_TICKCTL) begin
        next_st.prdata = {19'h0, st.ftw_tc, st.ctw_sel, st.wake_en,
                          st.sec_ie, st.ftw_ie, st.ctw_ie};
      end else if (paddr == OFF_FLAGS) begin
        next_st.prdata = {29'h0, st.flags};
      end else if (paddr == OFF_COUNT) begin
        next_st.prdata = {11'h0, st.ftw, 3'h0, st.central_tick_counter};
      end else if (paddr == OFF_BUSDIV) begin
        next_st.prdata = {16'h0, st.bus_div};
      end else if (paddr == OFF_CPUDIV) begin
        next_st.prdata = {28'h0, st.cpu_div};
      end else if (dclk_hit(paddr)) begin
        next_st.prdata = {13'h0, st.dc_src[paddr[4:2]], st.dc_div[paddr[4:2]]};
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    if (wr) begin
      if (paddr == OFF_CTRL) begin
        next_st.pll_en = pwdata[0];
        next_st.pll_ref = pwdata[2:1]; // R10
        next_st.imo_freq = pwdata[4:3]; // R17
        next_st.dbl_en = pwdata[5]; // R16
        next_st.dbl_src = pwdata[7:6];
      end else if (paddr == OFF_PLLDIV) begin
        next_st.pll_p = pwdata[5:0]; // R14
        next_st.pll_q = pwdata[13:8]; // R14
      end else if (paddr == OFF_TICKCTL) begin
        next_st.ctw_ie = pwdata[0];
        next_st.ftw_ie = pwdata[1];
        next_st.sec_ie = pwdata[2];
        next_st.wake_en = pwdata[3];
        next_st.ctw_sel = pwdata[7:4];
        next_st.ftw_tc = pwdata[12:8]; // R5
      end else if (paddr == OFF_BUSDIV) begin
        next_st.bus_div = pwdata[15:0];
      end else if (paddr == OFF_CPUDIV) begin
        next_st.cpu_div = pwdata[3:0]; // R18
      end else if (dclk_hit(paddr)) begin
        next_st.dc_div[paddr[4:2]] = pwdata[15:0]; // R19
        next_st.dc_src[paddr[4:2]] = pwdata[18:16]; // R19
      end
    end

    // A new event beats a write-one clear in the same cycle.
    if (wr && paddr == OFF_FLAGS) begin
      next_st.flags = (st.flags & ~pwdata[2:0]) | fset; // R23
    end else begin
      next_st.flags = st.flags | fset; // R23
    end
    // Masking before the register keeps each interrupt output straight from a flop.
    next_st.irq = next_st.flags & {next_st.sec_ie, next_st.ftw_ie, next_st.ctw_ie}; // R23
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.ftw_tc <= RST_FTW_TC;
      st.ctw_sel <= RST_CTW_SEL;
      st.pll_p <= RST_PLL_P;
      st.pll_q <= RST_PLL_Q;
      st.bus_div <= RST_BUS_DIV;
      st.cpu_div <= RST_CPU_DIV;
      for (int i = 0; i < 8; i++) begin
        st.dc_div[i] <= RST_DCLK_DIV;
      end
    end else begin
      st <= next_st;
    end
  end

  csatw_clkdiv #(.W(16)) u_bus (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .src_tick (1'b1),
    .div      (st.bus_div),
    .clk_out  (bus_clk),
    .tick     (bus_tick)
  );

  // The processor clock is taken from bus clock edges, never the master.
  csatw_clkdiv #(.W(4)) u_cpu (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .src_tick (bus_tick), // R22
    .div      (st.cpu_div), // R18
    .clk_out  (cpu_clk),
    .tick     ()
  );

  generate
    for (genvar g = 0; g < 8; g++) begin : g_dclk
      csatw_clkdiv #(.W(16)) u_dclk (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .src_tick (srcv[st.dc_src[g]]), // R19
        .div      (st.dc_div[g]),
        .clk_out  (dclk[g]),
        .tick     ()
      );
    end
  endgenerate

  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign pll_en       = st.pll_en;
  assign pll_ref      = st.pll_ref;
  assign pll_p        = st.pll_p;
  assign pll_q        = st.pll_q;
  assign pll_lock_out = st.locked; // R13
  assign imo_freq     = st.imo_freq;
  assign dbl_en       = st.dbl_en;
  assign dbl_src      = st.dbl_src;
  assign slow_tick_clock      = st.slow_t;
  assign fast_low_power_clock = st.fast_t;
  assign third_rate_clock     = st.third_t;
  assign ctw_irq = st.irq[FL_CTW];
  assign ftw_irq = st.irq[FL_FTW];
  assign sec_irq = st.irq[FL_SEC];
  assign wake    = st.wake;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_ctw_adv;
    (ctw_adv && !ctw_clr) |=> st.central_tick_counter == $past(st.central_tick_counter) + 13'h0001;
  endproperty
  a_ctw_adv: assert property (p_ctw_adv) else $error("central count missed"); // R1

  property p_ctw_stop;
    ((hibernate || debug_halt) && !ctw_clr) |=> $stable(st.central_tick_counter);
  endproperty
  a_ctw_stop: assert property (p_ctw_stop) else $error("central count moved"); // R2

  property p_ctw_clr;
    ctw_clr |=> st.central_tick_counter == 13'h0000;
  endproperty
  a_ctw_clr: assert property (p_ctw_clr) else $error("central clear lost"); // R4

  sequence s_ftw_term;
    rise[PIN_100K] && st.ftw == st.ftw_tc;
  endsequence
  property p_ftw_wrap;
    s_ftw_term |=> st.ftw == 5'h00;
  endproperty
  a_ftw_wrap: assert property (p_ftw_wrap) else $error("fast count no wrap"); // R6

  property p_ftw_irq;
    (s_ftw_term ##0 st.ftw_ie) |=> st.flags[FL_FTW] ##1 ftw_irq;
  endproperty
  a_ftw_irq: assert property (p_ftw_irq) else $error("fast irq missing"); // R7

  property p_flag_gate;
    (!st.ftw_ie && !st.flags[FL_FTW]) |=> !st.flags[FL_FTW];
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("flag while disabled"); // R23

  property p_third;
    (rise[PIN_100K] && st.div3 == DIV3_LAST) |=> third_rate_clock ##1 !third_rate_clock;
  endproperty
  a_third: assert property (p_third) else $error("third rate missing"); // R9

  property p_lock;
    (st.pll_en && !st.locked && st.lock_cnt == LOCK_LAST && !cfg_chg) |=> st.locked && pll_lock_out;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not set"); // R11

  property p_relock;
    cfg_chg |=> !st.locked ##1 !st.locked;
  endproperty
  a_relock: assert property (p_relock) else $error("lock kept on change"); // R24

  property p_apb;
    (psel && penable && !pready) |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb no answer");
endmodule : csatw_top

// File: testbench/csatw_top_test.sv
// Purpose: Self-checking bench for the clock sources and tick counters block.
// Assumes: Oscillator pins are driven as slow square waves from clk_sys edges.
// Notes:   The watch pin toggles every cycle so the one-second count fits the run budget.
`timescale 1ns/1ns
module csatw_top_test
  import csatw_pkg::*;
;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, dclk;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  pins;
  logic        hibernate, debug_halt, pll_en, pll_lock_out, dbl_en;
  logic [1:0]  pll_ref, imo_freq, dbl_src, dsrc, refv, imov;
  logic [5:0]  pll_p, pll_q, pv, qv;
  logic        slow_tick_clock, fast_low_power_clock, third_rate_clock;
  logic        ctw_irq, ftw_irq, sec_irq, wake, bus_clk, cpu_clk;
  logic [4:0]  tc;
  integer      seed;
  int          fails, checks, cyc, n1k, n100k, t1k, t3, wk, nd, di, tf;
  int          hi[10], ri[10];

  csatw_top dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc_1k(pins[PIN_1K]), .fast_osc_100k(pins[PIN_100K]), .watch_xtal_osc(pins[PIN_WATCH]),
    .dsi_clk(pins[PIN_DSI]), .fast_crystal_osc(pins[PIN_XTAL]), .hibernate(hibernate),
    .debug_halt(debug_halt), .pll_en(pll_en), .pll_ref(pll_ref), .pll_p(pll_p), .pll_q(pll_q),
    .pll_lock_out(pll_lock_out), .imo_freq(imo_freq), .dbl_en(dbl_en), .dbl_src(dbl_src),
    .slow_tick_clock(slow_tick_clock), .fast_low_power_clock(fast_low_power_clock),
    .third_rate_clock(third_rate_clock), .ctw_irq(ctw_irq), .ftw_irq(ftw_irq), .sec_irq(sec_irq),
    .wake(wake), .bus_clk(bus_clk), .cpu_clk(cpu_clk), .dclk(dclk)
  );

  always #50 clk_sys = ~clk_sys;

  // Pulse counters run beside the sequence so no one-cycle pulse is missed.
  always @(posedge clk_sys) begin
    cyc++;
    if (!sys_rst) begin
      t1k += int'(slow_tick_clock);
      t3  += int'(third_rate_clock);
      tf  += int'(fast_low_power_clock);
      wk  += int'(wake);
    end
    if (cyc == 90000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic edge_pin(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pins[idx] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pins[idx] <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    if (idx == PIN_1K) n1k += n;
    if (idx == PIN_100K) n100k += n;
  endtask : edge_pin

  task automatic meas(input int n);
    logic [9:0] prev;
    logic [9:0] now;
    prev = {bus_clk, cpu_clk, dclk};
    for (int k = 0; k < 10; k++) begin
      hi[k] = 0;
      ri[k] = 0;
    end
    repeat (n) begin
      @(posedge clk_sys);
      now = {bus_clk, cpu_clk, dclk};
      for (int k = 0; k < 10; k++) begin
        hi[k] += int'(now[k]);
        ri[k] += int'(now[k] & ~prev[k]);
      end
      prev = now;
    end
  endtask : meas

  function automatic logic [31:0] tick_word(input logic [4:0] t, input logic [3:0] sel,
                                            input logic [3:0] ie, input logic clr);
    return {15'h0, clr, 3'h0, t, sel, ie};
  endfunction : tick_word

  function automatic logic [31:0] pll_word(input logic [5:0] p, input logic [5:0] q, input logic lk);
    return {15'h0, lk, 2'h0, q, 2'h0, p};
  endfunction : pll_word

  function automatic logic [31:0] cnt_word(input logic [4:0] f, input logic [12:0] c);
    return {11'h0, f, 3'h0, c};
  endfunction : cnt_word

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pins, hibernate, debug_halt} = '0;
    seed = 32'he725;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, OFF_PLLDIV, 32'h0);
    chk(rd, pll_word(RST_PLL_P, RST_PLL_Q, 1'b0));
    apb(1'b0, OFF_TICKCTL, 32'h0);
    chk(rd, tick_word(RST_FTW_TC, RST_CTW_SEL, 4'h0, 1'b0));
    apb(1'b0, OFF_CPUDIV, 32'h0);
    chk(rd, {28'h0, RST_CPU_DIV});
    apb(1'b0, 8'h1c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 12; i++) begin
      dsrc = 2'($random(seed));
      refv = 2'(i % 3);
      imov = 2'(i / 3);
      apb(1'b1, OFF_CTRL, {24'h0, dsrc, 1'b1, imov, refv, 1'b0});
      @(posedge clk_sys);
      chk({24'h0, dbl_src, dbl_en, imo_freq, pll_ref, pll_en}, {24'h0, dsrc, 1'b1, imov, refv, 1'b0});
    end
    apb(1'b1, OFF_CTRL, 32'h00000019);
    repeat (1000) @(posedge clk_sys);
    chk({30'h0, pll_en, pll_lock_out}, 32'h2);
    repeat (1600) @(posedge clk_sys);
    chk({31'h0, pll_lock_out}, 32'h1);
    apb(1'b0, OFF_PLLDIV, 32'h0);
    chk(rd, pll_word(RST_PLL_P, RST_PLL_Q, 1'b1));
    pv = 6'($random(seed)) | 6'h20;
    qv = 6'($random(seed));
    apb(1'b1, OFF_PLLDIV, pll_word(pv, qv, 1'b0));
    repeat (2) @(posedge clk_sys);
    chk({19'h0, pll_lock_out, pll_q, pll_p}, {19'h0, 1'b0, qv, pv});
    repeat (2600) @(posedge clk_sys);
    chk({31'h0, pll_lock_out}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, pll_lock_out}, 32'h0);
    // Central counter with the shortest period, wake on.
    apb(1'b1, OFF_TICKCTL, tick_word(5'h1f, 4'h0, 4'b1001, 1'b1));
    edge_pin(PIN_1K, 1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    edge_pin(PIN_1K, 1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk({rd[31:1], ctw_irq}, 32'h1);
    apb(1'b1, OFF_FLAGS, 32'h1);
    @(posedge clk_sys);
    chk({31'h0, ctw_irq}, 32'h0);
    hibernate <= 1'b1;
    edge_pin(PIN_1K, 3);
    hibernate  <= 1'b0;
    debug_halt <= 1'b1;
    edge_pin(PIN_1K, 2);
    debug_halt <= 1'b0;
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(rd, cnt_word(5'h0, 13'd2));
    nd = 3 + (($random(seed) & 32'h7fff) % 8);
    apb(1'b1, OFF_TICKCTL, tick_word(5'h1f, 4'h0, 4'b0000, 1'b0));
    edge_pin(PIN_1K, nd);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(rd, cnt_word(5'h0, 13'(2 + nd)));
    apb(1'b1, OFF_TICKCTL, tick_word(5'h1f, 4'h0, 4'b0000, 1'b1));
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(rd, cnt_word(5'h0, 13'h0));
    edge_pin(PIN_1K, 2);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    // Fast counter: terminal count, wrap and interrupt gating.
    tc = 5'(2 + ($random(seed) & 7));
    apb(1'b1, OFF_TICKCTL, tick_word(tc, 4'h0, 4'b0010, 1'b0));
    edge_pin(PIN_100K, tc - 1);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(rd, cnt_word(tc - 5'h1, 13'd2));
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    edge_pin(PIN_100K, 2);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(rd, cnt_word(5'h0, 13'd2));
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk({rd[31:1], ftw_irq}, 32'h3);
    apb(1'b1, OFF_FLAGS, 32'h2);
    apb(1'b1, OFF_TICKCTL, tick_word(tc, 4'h0, 4'b0000, 1'b0));
    edge_pin(PIN_100K, tc + 1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk({rd[31:1], ftw_irq}, 32'h0);
    // Dividers: exact rise and high counts over whole periods.
    meas(60);
    chk(ri[8], 32'd15);
    chk(ri[9], 32'd30);
    repeat (3) begin
      di = ($random(seed) & 7);
      nd = 2 + (($random(seed) & 32'h7fff) % 5);
      apb(1'b1, OFF_DCLK0 + 8'(4 * di), 32'(nd));
      apb(1'b0, OFF_DCLK0 + 8'(4 * di), 32'h0);
      chk(rd, 32'(nd));
      repeat (8) @(posedge clk_sys);
      meas(60);
      chk(ri[di], 32'(60 / nd));
      chk(hi[di], 32'((60 / nd) * (nd / 2)));
    end
    // Digital divider fed from bus clock edges instead of the master.
    apb(1'b1, OFF_DCLK0, 32'h0006_0003);
    repeat (8) @(posedge clk_sys);
    meas(60);
    chk(ri[0], 32'd10);
    chk(hi[0], 32'd20);
    // One second of watch edges.
    apb(1'b1, OFF_TICKCTL, tick_word(tc, 4'h0, 4'b0100, 1'b0));
    repeat (32767) begin
      @(posedge clk_sys);
      pins[PIN_WATCH] <= 1'b1;
      @(posedge clk_sys);
      pins[PIN_WATCH] <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    chk({31'h0, sec_irq}, 32'h0);
    edge_pin(PIN_WATCH, 1);
    chk({31'h0, sec_irq}, 32'h1);
    apb(1'b1, OFF_FLAGS, 32'h4);
    @(posedge clk_sys);
    chk({31'h0, sec_irq}, 32'h0);
    chk(t1k, n1k);
    chk(t3, n100k / 3);
    chk(tf, n100k);
    chk(wk, 32'd1);
    end_sim();
  end
endmodule : csatw_top_test
